// ==== ccr_pkg.sv ====
// constants, masks and carrier types for the configuration control register bank
// Behaviour
// - Bit 7 of config_ctrl_one makes address region three management address space.
// - No-lock bit keeps lock pin negated except page table and acknowledge cycles.
// - With no-lock set, formerly locked noncacheable cycles run unlocked and may cache.
// - Management memory access bit routes management space to management memory, ignores interrupt.
// - Management pin enable gates the interrupt input and drives active output inactive.
// - Suspend pin enable gates suspend request; acknowledge output floats when clear.
// - Legacy region write protect guards cacheable accesses from 640 KB to 1 MB.
// - Suspend on halt enters low power suspend when halt executes.
// - Freeze bit makes the not-write-through flag read only.
// - Bus idle insert adds idle cycle after burst ready and before strobe.
// - Map enable 1h opens all indexes; 0h only C0-CFh, FEh, FFh.
// - Linear burst bit selects linear order, else interleaved one-plus-four order.
// - Nested non-maskable enable lets NMI through during management service; software sets it.
// - Management lock lets guarded settings change only inside management service routine.
// - Lock, once set, stays set until the reset pin.
// - Id instruction enable frees the id flag; else instruction raises invalid opcode.
// - I/O recovery field spaces I/O accesses 1..64 clocks, 7h none, reset 5h.
// - Index written to port 22h, data through 23h, one fresh index per transfer.
// - All bits clear at reset unless another reset value is given.
// - Region enable bit gates region registers; region three stays on with bit 7 of config_ctrl_one.
// - Write miss allocate allocates on read and write misses, else reads only.
package ccr_pkg;
   localparam logic [7:0] PORT_INDEX = 8'h22;
   localparam logic [7:0] PORT_DATA  = 8'h23;
   localparam logic [7:0] IDX_ONE    = 8'hc1;
   localparam logic [7:0] IDX_TWO    = 8'hc2;
   localparam logic [7:0] IDX_THREE  = 8'hc3;
   localparam logic [7:0] IDX_FOUR   = 8'he8;
   localparam logic [7:0] IDX_FIVE   = 8'he9;
   localparam logic [7:0] IDX_OPEN_LO = 8'hc0;
   localparam logic [7:0] IDX_OPEN_HI = 8'hcf;
   localparam logic [7:0] IDX_TOP_A  = 8'hfe;
   localparam logic [7:0] IDX_TOP_B  = 8'hff;
   localparam logic [3:0] MAP_ALL    = 4'h1;
   // writable bit masks, everything else reserved
   localparam logic [7:0] MASK_ONE   = 8'h96;
   localparam logic [7:0] MASK_TWO   = 8'h9e;
   localparam logic [7:0] MASK_THREE = 8'hf7;
   localparam logic [7:0] MASK_FOUR  = 8'h87;
   localparam logic [7:0] MASK_FIVE  = 8'h21;
   // bits frozen by the management lock
   localparam logic [7:0] GUARD_ONE   = 8'h86;
   localparam logic [7:0] GUARD_THREE = 8'h02;
   localparam logic [7:0] RST_ONE    = 8'h00;
   localparam logic [7:0] RST_TWO    = 8'h00;
   localparam logic [7:0] RST_THREE  = 8'h00;
   localparam logic [7:0] RST_FOUR   = 8'h05;
   localparam logic [7:0] RST_FIVE   = 8'h00;
   localparam int B1_REGION3 = 7;
   localparam int B1_NOLOCK  = 4;
   localparam int B1_MACCESS = 2;
   localparam int B1_MPINS   = 1;
   localparam int B2_SUSPEN  = 7;
   localparam int B2_WPROT   = 4;
   localparam int B2_SUSHLT  = 3;
   localparam int B2_FREEZE  = 2;
   localparam int B2_IDLE    = 1;
   localparam int B3_MAP_LO  = 4;
   localparam int B3_LINBUR  = 2;
   localparam int B3_NMIEN   = 1;
   localparam int B3_LOCK    = 0;
   localparam int B4_IDEN    = 7;
   localparam int B5_REGEN   = 5;
   localparam int B5_WALLOC  = 0;
   localparam logic [2:0] RECOVERY_NONE = 3'h7;
   localparam logic [31:0] LEGACY_LO = 32'h000a0000;
   localparam logic [31:0] LEGACY_HI = 32'h00100000;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] port;
      logic [7:0] data;
   } ccr_io_req_t;
endpackage : ccr_pkg

// ==== ccr_regs.sv ====
// configuration control register bank with index/data port access
`timescale 1ns/1ns
module ccr_regs #(
   parameter int GAP_W = 7
) (
   input  wire logic             mclk_i,
   input  wire logic             rst_n_i,
   input  wire ccr_pkg::ccr_io_req_t io_req_i,
   output logic                  io_rsp_valid_o,
   output logic                  io_claim_o,
   output logic [7:0]            io_rdata_o,
   input  wire logic             smm_active_i,
   input  wire logic             mgmt_irq_i,
   input  wire logic             in_mgmt_space_i,
   input  wire logic             lock_req_i,
   input  wire logic             pt_access_i,
   input  wire logic             inta_cycle_i,
   input  wire logic             suspend_req_i,
   input  wire logic             suspend_done_i,
   input  wire logic             halt_exec_i,
   input  wire logic             cacheable_i,
   input  wire logic [31:0]      mem_addr_i,
   input  wire logic             nmi_i,
   input  wire logic             id_instr_exec_i,
   input  wire logic             io_cycle_done_i,
   output logic                  region3_is_mgmt_space_o,
   output logic                  address_strobe_lock_n_o,
   output logic                  locked_internal_o,
   output logic                  lock_cacheable_ok_o,
   output logic                  mgmt_memory_sel_o,
   output logic                  mgmt_irq_take_o,
   output logic                  mgmt_active_pin_n_o,
   output logic                  suspend_take_o,
   output logic                  suspend_ack_pin_n_o,
   output logic                  suspend_ack_pin_oe_n_o,
   output logic                  legacy_wprotect_o,
   output logic                  suspend_enter_o,
   output logic                  wt_flag_write_allow_o,
   output logic                  bus_idle_insert_o,
   output logic                  linear_burst_order_o,
   output logic                  nmi_take_o,
   output logic                  region3_cfg_wr_ok_o,
   output logic                  id_instruction_enable_o,
   output logic                  invalid_opcode_o,
   output logic                  io_gap_busy_o,
   output logic                  region_regs_enable_o,
   output logic                  region3_enable_o,
   output logic                  write_miss_allocate_o
);

   logic [7:0]       ctl_one_q;
   logic [7:0]       ctl_two_q;
   logic [7:0]       ctl_three_q;
   logic [7:0]       ctl_four_q;
   logic [7:0]       ctl_five_q;
   logic [7:0]       index_q;
   logic             idx_valid_q;
   logic             rsp_valid_q;
   logic             claim_q;
   logic [7:0]       rdata_q;
   logic [GAP_W-1:0] gap_cnt_q;
   logic [GAP_W-1:0] gap_cnt_d;

   // port decode
   wire wr_index = io_req_i.wr && (io_req_i.port == ccr_pkg::PORT_INDEX);
   wire data_acc = (io_req_i.wr || io_req_i.rd)
                   && (io_req_i.port == ccr_pkg::PORT_DATA);

   // index reachability
   wire [3:0] map_en  = ctl_three_q[ccr_pkg::B3_MAP_LO +: 4];
   wire idx_open = ((index_q >= ccr_pkg::IDX_OPEN_LO)
                    && (index_q <= ccr_pkg::IDX_OPEN_HI))
                   || (index_q == ccr_pkg::IDX_TOP_A)
                   || (index_q == ccr_pkg::IDX_TOP_B);
   wire reachable = idx_open || (map_en == ccr_pkg::MAP_ALL);

   wire sel1 = index_q == ccr_pkg::IDX_ONE;
   wire sel2 = index_q == ccr_pkg::IDX_TWO;
   wire sel3 = index_q == ccr_pkg::IDX_THREE;
   wire sel4 = index_q == ccr_pkg::IDX_FOUR;
   wire sel5 = index_q == ccr_pkg::IDX_FIVE;
   wire implemented = sel1 || sel2 || sel3 || sel4 || sel5;

   // a data access counts only behind a fresh index
   wire hit   = data_acc && idx_valid_q && reachable && implemented;
   wire hit_w = hit && io_req_i.wr;
   wire hit_r = hit && io_req_i.rd;

   // guarded fields freeze outside the service routine once locked
   wire lock_on = ctl_three_q[ccr_pkg::B3_LOCK];
   wire frozen  = lock_on && !smm_active_i;

   wire [7:0] wd = io_req_i.data;
   wire [7:0] g1 = frozen ? ccr_pkg::GUARD_ONE : 8'h00;
   wire [7:0] g3 = frozen ? ccr_pkg::GUARD_THREE : 8'h00;

   // reserved bits dropped on write
   wire [7:0] ctl_one_w = ((ctl_one_q & g1) | (wd & ~g1))
                          & ccr_pkg::MASK_ONE;
   wire [7:0] ctl_two_w = wd & ccr_pkg::MASK_TWO;
   wire [7:0] ctl_three_m = ((ctl_three_q & g3) | (wd & ~g3))
                            & ccr_pkg::MASK_THREE;
   // lock can only be raised by software, never lowered
   wire [7:0] ctl_three_w = ctl_three_m | {7'h00, lock_on};
   wire [7:0] ctl_four_w = wd & ccr_pkg::MASK_FOUR;
   wire [7:0] ctl_five_w = wd & ccr_pkg::MASK_FIVE;

   wire [7:0] rd_mux = sel1 ? ctl_one_q :
                       sel2 ? ctl_two_q :
                       sel3 ? ctl_three_q :
                       sel4 ? ctl_four_q :
                       ctl_five_q;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctl_one_q   <= ccr_pkg::RST_ONE;
         ctl_two_q   <= ccr_pkg::RST_TWO;
         ctl_three_q <= ccr_pkg::RST_THREE;
         ctl_four_q  <= ccr_pkg::RST_FOUR;
         ctl_five_q  <= ccr_pkg::RST_FIVE;
      end else if (hit_w) begin
         if (sel1) ctl_one_q <= ctl_one_w;
         if (sel2) ctl_two_q <= ctl_two_w;
         if (sel3) ctl_three_q <= ctl_three_w;
         if (sel4) ctl_four_q <= ctl_four_w;
         if (sel5) ctl_five_q <= ctl_five_w;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         index_q     <= 8'h00;
         idx_valid_q <= 1'b0;
      end else if (wr_index) begin
         index_q     <= io_req_i.data;
         idx_valid_q <= 1'b1;
      end else if (data_acc) begin
         idx_valid_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rsp_valid_q <= 1'b0;
         claim_q     <= 1'b0;
         rdata_q     <= 8'h00;
      end else begin
         rsp_valid_q <= data_acc || wr_index;
         claim_q     <= hit || wr_index;
         rdata_q     <= hit_r ? rd_mux : 8'h00;
      end
   end

   assign io_rsp_valid_o = rsp_valid_q;
   assign io_claim_o     = claim_q;
   assign io_rdata_o     = rdata_q;

   // i/o recovery spacing
   wire [2:0] recov_code = ctl_four_q[2:0];
   wire [GAP_W-1:0] gap_load = (recov_code == ccr_pkg::RECOVERY_NONE) ? '0 :
                               GAP_W'(8'h01 << recov_code);
   always_comb begin
      gap_cnt_d = gap_cnt_q;
      if (io_cycle_done_i) begin
         gap_cnt_d = gap_load;
      end else if (gap_cnt_q != '0) begin
         gap_cnt_d = gap_cnt_q - GAP_W'(1);
      end
   end
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) gap_cnt_q <= '0;
      else gap_cnt_q <= gap_cnt_d;
   end
   assign io_gap_busy_o = gap_cnt_q != '0;

   // decoded feature bits
   wire region3   = ctl_one_q[ccr_pkg::B1_REGION3];
   wire no_lock   = ctl_one_q[ccr_pkg::B1_NOLOCK];
   wire m_access  = ctl_one_q[ccr_pkg::B1_MACCESS];
   wire m_pins    = ctl_one_q[ccr_pkg::B1_MPINS];
   wire suspend_request_pin_en   = ctl_two_q[ccr_pkg::B2_SUSPEN];
   wire wprot     = ctl_two_q[ccr_pkg::B2_WPROT];
   wire sus_hlt   = ctl_two_q[ccr_pkg::B2_SUSHLT];
   wire freeze_wt = ctl_two_q[ccr_pkg::B2_FREEZE];
   wire nmi_en    = ctl_three_q[ccr_pkg::B3_NMIEN];
   wire legacy_hit = (mem_addr_i >= ccr_pkg::LEGACY_LO)
                     && (mem_addr_i < ccr_pkg::LEGACY_HI);

   assign region3_is_mgmt_space_o = region3;
   // acknowledge cycles still run locked inside and assert the pin even with no-lock set
   assign address_strobe_lock_n_o = !(lock_req_i
                                      && (!no_lock || pt_access_i
                                          || inta_cycle_i));
   assign locked_internal_o = lock_req_i && (!no_lock || pt_access_i
                                             || inta_cycle_i);
   assign lock_cacheable_ok_o = no_lock;
   assign mgmt_memory_sel_o = m_access && in_mgmt_space_i;
   assign mgmt_irq_take_o = mgmt_irq_i && m_pins && !m_access;
   assign mgmt_active_pin_n_o = !(m_pins && smm_active_i);
   assign suspend_take_o = suspend_req_i && suspend_request_pin_en;
   assign suspend_ack_pin_n_o = !(suspend_request_pin_en && suspend_done_i);
   assign suspend_ack_pin_oe_n_o = !suspend_request_pin_en;
   assign legacy_wprotect_o = wprot && cacheable_i && legacy_hit;
   assign suspend_enter_o = sus_hlt && halt_exec_i;
   assign wt_flag_write_allow_o = !freeze_wt;
   assign bus_idle_insert_o = ctl_two_q[ccr_pkg::B2_IDLE];
   assign linear_burst_order_o = ctl_three_q[ccr_pkg::B3_LINBUR];
   // nesting only matters while the service routine runs
   assign nmi_take_o = nmi_i && (!smm_active_i || nmi_en);
   assign region3_cfg_wr_ok_o = !frozen;
   assign id_instruction_enable_o = ctl_four_q[ccr_pkg::B4_IDEN];
   assign invalid_opcode_o = id_instr_exec_i
                             && !ctl_four_q[ccr_pkg::B4_IDEN];
   assign region_regs_enable_o = ctl_five_q[ccr_pkg::B5_REGEN];
   assign region3_enable_o = ctl_five_q[ccr_pkg::B5_REGEN] || region3;
   assign write_miss_allocate_o = ctl_five_q[ccr_pkg::B5_WALLOC];

   a_lock_sticky: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      lock_on |=> ctl_three_q[ccr_pkg::B3_LOCK])
      else $error("lock bit cleared without reset");

   a_guard_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      hit_w && sel1 && frozen |=>
         ((ctl_one_q & ccr_pkg::GUARD_ONE)
          == ($past(ctl_one_q) & ccr_pkg::GUARD_ONE)))
      else $error("guarded bits changed while locked");

   a_index_once: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      data_acc && !idx_valid_q |=> rsp_valid_q && !claim_q && (io_rdata_o == 8'h00))
      else $error("data access claimed without fresh index");

   a_map_block: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      data_acc && idx_valid_q && sel4 && (map_en != ccr_pkg::MAP_ALL)
         |=> rsp_valid_q && !claim_q)
      else $error("hidden index answered with map disabled");

   a_read_back: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      hit_r && sel2 |=> claim_q && (io_rdata_o == $past(ctl_two_q)))
      else $error("read data does not match register");

   a_rsv_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      ((ctl_one_q & ~ccr_pkg::MASK_ONE) == 8'h00)
      && ((ctl_four_q & ~ccr_pkg::MASK_FOUR) == 8'h00))
      else $error("reserved bit set");

   // busy covers the four clocks after the pulse, so look one clock later
   a_gap_one: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      io_cycle_done_i && recov_code == 3'h2 ##1 !io_cycle_done_i [*4]
         |=> !io_gap_busy_o)
      else $error("recovery gap not four clocks");

   a_gap_busy: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      io_cycle_done_i && recov_code == 3'h1 |=> io_gap_busy_o ##1
         (io_gap_busy_o || io_cycle_done_i))
      else $error("recovery gap ended early");

   a_suspend_request_pin_float: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      !suspend_request_pin_en |-> suspend_ack_pin_oe_n_o && !suspend_take_o)
      else $error("suspend pins active while disabled");

   a_lock_pin: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      no_lock && lock_req_i && !pt_access_i && !inta_cycle_i
         |-> address_strobe_lock_n_o)
      else $error("lock pin asserted with no-lock set");

   a_wprot_hit: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      wprot && cacheable_i && mem_addr_i == 32'h000fffff |-> legacy_wprotect_o)
      else $error("legacy region not write protected");

   a_irq_gate: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      !m_pins |-> !mgmt_irq_take_o && mgmt_active_pin_n_o)
      else $error("management pins active while disabled");

endmodule : ccr_regs

// ==== ccr_regs_tb.sv ====
// self-checking testbench for the configuration control register bank
`timescale 1ns/1ns
module ccr_regs_tb;
   logic                 mclk_i = 1'b0;
   logic                 rst_n_i = 1'b0;
   ccr_pkg::ccr_io_req_t io_req_i = '0;
   logic                 smm_active_i = 1'b0, mgmt_irq_i = 1'b0, in_mgmt_space_i = 1'b0;
   logic                 lock_req_i = 1'b0, pt_access_i = 1'b0, inta_cycle_i = 1'b0;
   logic                 suspend_req_i = 1'b0, suspend_done_i = 1'b0, halt_exec_i = 1'b0;
   logic                 cacheable_i = 1'b0, nmi_i = 1'b0, id_instr_exec_i = 1'b0;
   logic                 io_cycle_done_i = 1'b0;
   logic [31:0]          mem_addr_i = 32'h00000000;
   logic                 rsp_o, claim_o, r3m_o, lkn_o, lki_o, lco_o, msel_o, mirq_o, mact_o;
   logic                 stake_o, sackn_o, soen_o, wpr_o, sent_o, nwa_o, idle_o, lin_o, nmi_o;
   logic                 r3ok_o, iden_o, inv_o, busy_o, ren_o, r3en_o, wal_o;
   logic [7:0]           rdata_o;
   int                   n_errors = 0;
   int                   samples_checked = 0;

   always #25 mclk_i = ~mclk_i;

   ccr_regs #(.GAP_W(7)) ccr_regs_i (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .io_req_i(io_req_i), .io_rsp_valid_o(rsp_o),
      .io_claim_o(claim_o), .io_rdata_o(rdata_o), .smm_active_i(smm_active_i),
      .mgmt_irq_i(mgmt_irq_i), .in_mgmt_space_i(in_mgmt_space_i), .lock_req_i(lock_req_i),
      .pt_access_i(pt_access_i), .inta_cycle_i(inta_cycle_i), .suspend_req_i(suspend_req_i),
      .suspend_done_i(suspend_done_i), .halt_exec_i(halt_exec_i), .cacheable_i(cacheable_i),
      .mem_addr_i(mem_addr_i), .nmi_i(nmi_i), .id_instr_exec_i(id_instr_exec_i),
      .io_cycle_done_i(io_cycle_done_i), .region3_is_mgmt_space_o(r3m_o),
      .address_strobe_lock_n_o(lkn_o), .locked_internal_o(lki_o),
      .lock_cacheable_ok_o(lco_o), .mgmt_memory_sel_o(msel_o), .mgmt_irq_take_o(mirq_o),
      .mgmt_active_pin_n_o(mact_o), .suspend_take_o(stake_o), .suspend_ack_pin_n_o(sackn_o),
      .suspend_ack_pin_oe_n_o(soen_o), .legacy_wprotect_o(wpr_o), .suspend_enter_o(sent_o),
      .wt_flag_write_allow_o(nwa_o), .bus_idle_insert_o(idle_o), .linear_burst_order_o(lin_o),
      .nmi_take_o(nmi_o), .region3_cfg_wr_ok_o(r3ok_o), .id_instruction_enable_o(iden_o),
      .invalid_opcode_o(inv_o), .io_gap_busy_o(busy_o), .region_regs_enable_o(ren_o),
      .region3_enable_o(r3en_o), .write_miss_allocate_o(wal_o));

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk8

   task automatic chk1(input logic got, input logic exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask : chk1

   // called at a falling edge; answer stands one cycle only, so checked at the next one
   task automatic io_op(input logic wr, input logic [7:0] port, input logic [7:0] data,
                        input logic exp_claim, input logic [7:0] exp_rd);
      io_req_i = '{wr: wr, rd: ~wr, port: port, data: data};
      @(negedge mclk_i);
      chk1(rsp_o, 1'b1, "response valid");
      chk1(claim_o, exp_claim, "claim");
      chk8(rdata_o, exp_rd, "read data");
      io_req_i = '0;
      @(negedge mclk_i);
   endtask : io_op

   task automatic reg_wr(input logic [7:0] idx, input logic [7:0] data);
      io_op(1'b1, ccr_pkg::PORT_INDEX, idx, 1'b1, 8'h00);
      io_op(1'b1, ccr_pkg::PORT_DATA, data, 1'b1, 8'h00);
   endtask : reg_wr

   task automatic reg_rd(input logic [7:0] idx, input logic claim, input logic [7:0] exp);
      io_op(1'b1, ccr_pkg::PORT_INDEX, idx, 1'b1, 8'h00);
      io_op(1'b0, ccr_pkg::PORT_DATA, 8'h00, claim, exp);
   endtask : reg_rd

   // one recovery pulse, then count busy cycles; 70 covers the longest spacing
   task automatic gap_cnt(input int exp);
      int n;
      n = 0;
      io_cycle_done_i = 1'b1;
      @(negedge mclk_i);
      io_cycle_done_i = 1'b0;
      repeat (70) begin
         if (busy_o === 1'b1) n++;
         @(negedge mclk_i);
      end
      chk8(n[7:0], exp[7:0], "recovery clocks");
   endtask : gap_cnt

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : final_report

   initial begin
      repeat (4) @(posedge mclk_i);
      @(negedge mclk_i);
      rst_n_i = 1'b1;
      @(negedge mclk_i);
      chk1(soen_o, 1'b1, "ack output floats");
      reg_rd(ccr_pkg::IDX_ONE, 1'b1, 8'h00);
      reg_rd(ccr_pkg::IDX_TWO, 1'b1, 8'h00);
      reg_rd(ccr_pkg::IDX_THREE, 1'b1, 8'h00);
      reg_rd(ccr_pkg::IDX_FOUR, 1'b0, 8'h00);
      io_op(1'b0, ccr_pkg::PORT_DATA, 8'h00, 1'b0, 8'h00);
      gap_cnt(32);
      $display("test reset done");
      reg_wr(ccr_pkg::IDX_THREE, 8'h1e);
      reg_rd(ccr_pkg::IDX_THREE, 1'b1, 8'h16);
      reg_rd(ccr_pkg::IDX_FOUR, 1'b1, 8'h05);
      reg_wr(ccr_pkg::IDX_ONE, 8'hff);
      reg_wr(ccr_pkg::IDX_TWO, 8'hff);
      reg_wr(ccr_pkg::IDX_FOUR, 8'hff);
      reg_wr(ccr_pkg::IDX_FIVE, 8'hff);
      reg_rd(ccr_pkg::IDX_ONE, 1'b1, 8'h96);
      reg_rd(ccr_pkg::IDX_TWO, 1'b1, 8'h9e);
      reg_rd(ccr_pkg::IDX_FOUR, 1'b1, 8'h87);
      reg_rd(ccr_pkg::IDX_FIVE, 1'b1, 8'h21);
      $display("test masks done");
      {smm_active_i, mgmt_irq_i, in_mgmt_space_i, lock_req_i, suspend_req_i} = 5'h1f;
      {suspend_done_i, halt_exec_i, cacheable_i, nmi_i, id_instr_exec_i} = 5'h1f;
      mem_addr_i = 32'h000a0000;
      @(negedge mclk_i);
      chk1(r3m_o, 1'b1, "region three mgmt");
      chk1(lkn_o, 1'b1, "lock pin negated");
      chk1(lki_o, 1'b0, "runs unlocked");
      chk1(lco_o, 1'b1, "locked cacheable");
      chk1(msel_o, 1'b1, "mgmt memory");
      chk1(mirq_o, 1'b0, "irq ignored");
      chk1(mact_o, 1'b0, "active pin");
      chk1(stake_o, 1'b1, "suspend taken");
      chk1(sackn_o, 1'b0, "suspend ack");
      chk1(soen_o, 1'b0, "ack driven");
      chk1(wpr_o, 1'b1, "write protect");
      chk1(sent_o, 1'b1, "suspend on halt");
      chk1(nwa_o, 1'b0, "flag frozen");
      chk1(idle_o, 1'b1, "idle insert");
      chk1(lin_o, 1'b1, "linear burst");
      chk1(nmi_o, 1'b1, "nmi nested");
      chk1(iden_o, 1'b1, "id enable");
      chk1(inv_o, 1'b0, "no invalid opcode");
      chk1(ren_o, 1'b1, "regions on");
      chk1(wal_o, 1'b1, "write allocate");
      pt_access_i = 1'b1;
      mem_addr_i = 32'h00100000;
      @(negedge mclk_i);
      chk1(lkn_o, 1'b0, "page table locked");
      chk1(lki_o, 1'b1, "page table runs locked");
      chk1(wpr_o, 1'b0, "above legacy area");
      pt_access_i = 1'b0;
      inta_cycle_i = 1'b1;
      @(negedge mclk_i);
      chk1(lkn_o, 1'b0, "acknowledge locked");
      chk1(lki_o, 1'b1, "acknowledge runs locked");
      inta_cycle_i = 1'b0;
      $display("test outputs done");
      for (int c = 0; c < 8; c++) begin
         reg_wr(ccr_pkg::IDX_FOUR, {5'h10, 3'(c)});
         gap_cnt(c == 7 ? 0 : (1 << c));
      end
      $display("test recovery done");
      reg_wr(ccr_pkg::IDX_ONE, 8'h02);
      reg_wr(ccr_pkg::IDX_TWO, 8'h00);
      reg_wr(ccr_pkg::IDX_FIVE, 8'h00);
      @(negedge mclk_i);
      chk1(mirq_o, 1'b1, "irq taken");
      chk1(soen_o, 1'b1, "ack floats");
      chk1(stake_o, 1'b0, "suspend ignored");
      chk1(nwa_o, 1'b1, "flag writable");
      chk1(inv_o, 1'b0, "id still on");
      chk1(r3en_o, 1'b0, "region three off");
      reg_wr(ccr_pkg::IDX_FOUR, 8'h00);
      reg_wr(ccr_pkg::IDX_ONE, 8'h82);
      @(negedge mclk_i);
      chk1(inv_o, 1'b1, "invalid opcode");
      chk1(r3en_o, 1'b1, "region three kept");
      reg_wr(ccr_pkg::IDX_ONE, 8'h02);
      $display("test clear done");
      reg_wr(ccr_pkg::IDX_THREE, 8'h11);
      @(negedge mclk_i);
      chk1(nmi_o, 1'b0, "nmi blocked");
      smm_active_i = 1'b0;
      @(negedge mclk_i);
      chk1(r3ok_o, 1'b0, "region cfg locked");
      reg_wr(ccr_pkg::IDX_ONE, 8'hff);
      reg_rd(ccr_pkg::IDX_ONE, 1'b1, 8'h12);
      reg_wr(ccr_pkg::IDX_THREE, 8'h12);
      reg_rd(ccr_pkg::IDX_THREE, 1'b1, 8'h11);
      smm_active_i = 1'b1;
      reg_wr(ccr_pkg::IDX_ONE, 8'h00);
      reg_rd(ccr_pkg::IDX_ONE, 1'b1, 8'h00);
      reg_wr(ccr_pkg::IDX_THREE, 8'h10);
      reg_rd(ccr_pkg::IDX_THREE, 1'b1, 8'h11);
      chk1(r3ok_o, 1'b1, "cfg open in service");
      rst_n_i = 1'b0;
      @(negedge mclk_i);
      rst_n_i = 1'b1;
      @(negedge mclk_i);
      reg_rd(ccr_pkg::IDX_THREE, 1'b1, 8'h00);
      $display("test lock done");
      final_report();
   end

   // whole sequence needs about 800 cycles
   initial begin
      repeat (5000) @(posedge mclk_i);
      n_errors++;
      $display("wrong value at %0t: watchdog expired", $time);
      final_report();
   end
endmodule : ccr_regs_tb
